// File: design/ssr_receiver.sv
// Synchronous serial receiver with classic Wishbone register slave
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
module ssr_receiver
   import ssr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_we_i,
   input  wire logic [5:0] wb_adr_i,
   input  wire logic [3:0] wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]     wb_dat_o,
   output logic            wb_ack_o,
   input  wire logic       rx_data_pin,
   input  wire logic       sclk_in,
   output logic            sclk_out,
   output logic            sclk_oe,
   input  wire logic       low_power,
   output logic            irq,
   output logic            wake
);
   import ssr_pkg::*;

   logic [7:0]  receive_ctrl_status_a;
   logic [7:0]  transmit_ctrl_status_a;
   logic [7:0]  baud_control_a;
   logic [7:0]  baud_divisor_high_a;
   logic [7:0]  baud_divisor_low_a;
   logic [7:0]  receive_buffer_a;
   logic        receive_irq_enable_a;
   logic        receive_irq_flag_a;
   logic        ninth_received_bit;
   logic        overrun_error_flag;
   logic        pending;
   ssr_word_t   pend_word;
   ssr_cfg_t    cfg;
   ssr_state_t  state;
   logic [8:0]  receive_shift_register;
   logic [3:0]  bit_count;
   logic        data_s;
   logic        ext_fall;
   logic        gen_fall;
   logic        gen_sclk;
   logic        shift_fall;
   logic        master;
   logic        rx_enable;
   logic        run_clk;
   logic        word_done;
   logic [3:0]  word_bits;
   logic        access;
   logic        wr;
   logic        rd_buf;
   logic        cont_clear;
   logic [7:0]  new_byte;
   logic        new_ninth;
   logic [7:0]  rd_byte;
   logic [7:0]  status_rd;

   assign cfg.serial_port_enable = receive_ctrl_status_a[BIT_PORT_EN];
   assign cfg.nine_bit_receive_enable = receive_ctrl_status_a[BIT_NINE_EN];
   assign cfg.single_receive_enable = receive_ctrl_status_a[BIT_SINGLE_EN];
   assign cfg.continuous_receive_enable = receive_ctrl_status_a[BIT_CONT_EN];
   assign cfg.clock_source_select = transmit_ctrl_status_a[BIT_CLK_SRC];
   assign cfg.sync_select = transmit_ctrl_status_a[BIT_SYNC];
   assign cfg.low_power = low_power;

   ssr_sync u_data (
      .clk  (clk),
      .nrst (nrst),
      .din  (rx_data_pin),
      .dout (data_s),
      .fall ()
   );

   ssr_sync u_clk (
      .clk  (clk),
      .nrst (nrst),
      .din  (sclk_in),
      .dout (),
      .fall (ext_fall)
   );

   ssr_clkgen u_gen (
      .clk     (clk),
      .nrst    (nrst),
      .run     (run_clk),
      .divisor ({baud_divisor_high_a, baud_divisor_low_a}),
      .sclk    (gen_sclk),
      .fall    (gen_fall)
   );

   // Mode and enable decode
   assign master = cfg.clock_source_select;
   // Single enable only counts in master mode; continuous wins
   assign rx_enable = cfg.serial_port_enable & cfg.sync_select
      & (cfg.continuous_receive_enable
         | (master & cfg.single_receive_enable));
   // Master drives no clock in low power; slave keeps shifting
   assign run_clk = rx_enable & master & ~cfg.low_power;
   assign shift_fall = master ? gen_fall : ext_fall;
   assign sclk_out = gen_sclk;
   assign sclk_oe = cfg.serial_port_enable & cfg.sync_select & master;
   assign word_bits = cfg.nine_bit_receive_enable ? WORD_BITS_9
                                                  : WORD_BITS_8;
   assign word_done = (state == ST_SHIFT) & shift_fall
      & (bit_count == word_bits - 4'h1);

   // Receive state machine
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         bit_count <= 4'h0;
         receive_shift_register <= 9'h000;
      end else begin
         case (state)
            ST_IDLE: begin
               bit_count <= 4'h0;
               if (rx_enable) begin
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (!rx_enable) begin
                  state <= ST_IDLE;
               end else if (shift_fall) begin
                  // LSB first
                  receive_shift_register <=
                     {data_s, receive_shift_register[8:1]};
                  bit_count <= bit_count + 4'h1;
                  if (word_done) begin
                     state <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               bit_count <= 4'h0;
               // Continuous runs on, single stops
               if (cfg.continuous_receive_enable) begin
                  state <= ST_SHIFT;
               end else begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Single enable self-clears after one word, error cleared when continuous enable is written off
   assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = access & wb_we_i & wb_sel_i[0];
   assign rd_buf = access & ~wb_we_i & (wb_adr_i[5:2] == ADDR_RX_BUF);
   assign cont_clear = wr & (wb_adr_i[5:2] == ADDR_RX_CTRL)
      & ~wb_dat_i[BIT_CONT_EN] & receive_ctrl_status_a[BIT_CONT_EN];
   // Completed word as it leaves the shift register
   assign new_byte = cfg.nine_bit_receive_enable
      ? receive_shift_register[8:1]
      : {data_s, receive_shift_register[8:2]};
   assign new_ninth = data_s & cfg.nine_bit_receive_enable;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         receive_ctrl_status_a <= RESET_BYTE;
      end else if (wr && wb_adr_i[5:2] == ADDR_RX_CTRL) begin
         receive_ctrl_status_a <= wb_dat_i[7:0];
      end else if (state == ST_DONE
                   && !cfg.continuous_receive_enable) begin
         receive_ctrl_status_a[BIT_SINGLE_EN] <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         transmit_ctrl_status_a <= RESET_BYTE;
         baud_control_a <= RESET_BYTE;
         baud_divisor_high_a <= RESET_DIV[15:8];
         baud_divisor_low_a <= RESET_DIV[7:0];
         receive_irq_enable_a <= 1'b0;
      end else if (wr) begin
         if (wb_adr_i[5:2] == ADDR_TX_CTRL) begin
            transmit_ctrl_status_a <= wb_dat_i[7:0];
         end else if (wb_adr_i[5:2] == ADDR_BAUD_CTRL) begin
            baud_control_a <= wb_dat_i[7:0];
         end else if (wb_adr_i[5:2] == ADDR_DIV_HIGH) begin
            baud_divisor_high_a <= wb_dat_i[7:0];
         end else if (wb_adr_i[5:2] == ADDR_DIV_LOW) begin
            baud_divisor_low_a <= wb_dat_i[7:0];
         end else if (wb_adr_i[5:2] == ADDR_IRQ) begin
            receive_irq_enable_a <= wb_dat_i[BIT_IRQ_EN];
         end
      end
   end

   // Receive buffer with one pending word behind it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         receive_buffer_a <= RESET_BYTE;
         ninth_received_bit <= 1'b0;
         receive_irq_flag_a <= 1'b0;
         pending <= 1'b0;
         pend_word <= '0;
         overrun_error_flag <= 1'b0;
      end else begin
         if (cont_clear) begin
            overrun_error_flag <= 1'b0;
         end
         if (word_done
             && (!receive_irq_flag_a || (rd_buf && !pending))) begin
            // Set wins over the read clear
            receive_buffer_a <= new_byte;
            ninth_received_bit <= new_ninth;
            receive_irq_flag_a <= 1'b1;
         end else if (word_done && rd_buf) begin
            // Waiting word moves up, new word waits behind it
            receive_buffer_a <= pend_word.data;
            ninth_received_bit <= pend_word.ninth;
            pend_word.ninth <= new_ninth;
            pend_word.data <= new_byte;
         end else if (word_done && !pending) begin
            pending <= 1'b1;
            pend_word.valid <= 1'b1;
            pend_word.ninth <= new_ninth;
            pend_word.data <= new_byte;
         end else if (word_done) begin
            overrun_error_flag <= 1'b1;
         end else if (rd_buf && pending) begin
            receive_buffer_a <= pend_word.data;
            ninth_received_bit <= pend_word.ninth;
            pending <= 1'b0;
            pend_word.valid <= 1'b0;
         end else if (rd_buf) begin
            receive_irq_flag_a <= 1'b0;
         end
      end
   end

   assign irq = receive_irq_flag_a & receive_irq_enable_a;
   assign wake = irq & cfg.low_power;

   assign status_rd = {receive_ctrl_status_a[7:4], 2'b00,
                       overrun_error_flag, ninth_received_bit};

   always_comb begin
      if (wb_adr_i[5:2] == ADDR_RX_CTRL) begin
         rd_byte = status_rd;
      end else if (wb_adr_i[5:2] == ADDR_RX_BUF) begin
         rd_byte = receive_buffer_a;
      end else if (wb_adr_i[5:2] == ADDR_TX_CTRL) begin
         rd_byte = transmit_ctrl_status_a;
      end else if (wb_adr_i[5:2] == ADDR_BAUD_CTRL) begin
         rd_byte = baud_control_a;
      end else if (wb_adr_i[5:2] == ADDR_DIV_HIGH) begin
         rd_byte = baud_divisor_high_a;
      end else if (wb_adr_i[5:2] == ADDR_DIV_LOW) begin
         rd_byte = baud_divisor_low_a;
      end else if (wb_adr_i[5:2] == ADDR_IRQ) begin
         rd_byte = {6'h00, receive_irq_flag_a, receive_irq_enable_a};
      end else begin
         rd_byte = 8'h00;
      end
   end

   // Bus answer one cycle after request
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= {24'h000000, rd_byte};
      end
   end
endmodule // ssr_receiver

// File: common/ssr_pkg.sv
// Package for the synchronous serial receiver: offsets, fields, types
// Notes on behaviour
// - Master and slave receive alike except in low power; single enable ignored in slave mode.
// - Slave with continuous enable set still receives a word in low power.
// - Completed word moves from shift register into receive buffer.
// - Receive interrupt, when enabled, wakes the chip from low power.
// - Nine-bit mode captures the ninth bit into the status register.
// - Completion sets receive flag; interrupt only when enable is set.
// - Clearing continuous enable clears the error state.
// - Master reception starts when single or continuous enable set.
// - Master samples the data pin on the serial clock falling edge.
// - In master mode, single enable alone receives exactly one word then stops.
// - Continuous enable keeps receiving until software clears it.
// - Both enables set: continuous wins, single is ignored.
// - Receive buffer presents the lower eight bits of each word.
package ssr_pkg;
   localparam logic [3:0] ADDR_RX_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_RX_BUF    = 4'h1;
   localparam logic [3:0] ADDR_TX_CTRL   = 4'h2;
   localparam logic [3:0] ADDR_BAUD_CTRL = 4'h3;
   localparam logic [3:0] ADDR_DIV_HIGH  = 4'h4;
   localparam logic [3:0] ADDR_DIV_LOW   = 4'h5;
   localparam logic [3:0] ADDR_IRQ       = 4'h6;
   localparam int BIT_PORT_EN   = 7;
   localparam int BIT_NINE_EN   = 6;
   localparam int BIT_SINGLE_EN = 5;
   localparam int BIT_CONT_EN   = 4;
   localparam int BIT_OVERRUN   = 1;
   localparam int BIT_NINTH     = 0;
   localparam int BIT_CLK_SRC   = 7;
   localparam int BIT_SYNC  = 4;
   localparam int BIT_IRQ_EN   = 0;
   localparam int BIT_IRQ_FLAG = 1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_DIV = 16'h0000;
   localparam logic [3:0] WORD_BITS_8 = 4'h8;
   localparam logic [3:0] WORD_BITS_9 = 4'h9;

   typedef struct packed {
      logic       serial_port_enable;
      logic       nine_bit_receive_enable;
      logic       single_receive_enable;
      logic       continuous_receive_enable;
      logic       clock_source_select;
      logic       sync_select;
      logic       low_power;
   } ssr_cfg_t;

   typedef struct packed {
      logic       valid;
      logic       ninth;
      logic [7:0] data;
   } ssr_word_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE = 3'b100
   } ssr_state_t;
endpackage

// File: design/ssr_sync.sv
// Two-stage synchroniser with falling edge detect
`timescale 1ns/1ns
module ssr_sync (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic din,
   output logic      dout,
   output logic      fall
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end
   assign dout = s2;
   assign fall = s3 & ~s2;
endmodule // ssr_sync

// File: design/ssr_clkgen.sv
// Serial clock divider for master reception
`timescale 1ns/1ns
module ssr_clkgen (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        run,
   input  wire logic [15:0] divisor,
   output logic             sclk,
   output logic             fall
);
   logic [15:0] count;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= 16'h0000;
         sclk  <= 1'b1;
      end else if (!run) begin
         count <= 16'h0000;
         sclk  <= 1'b1;
      end else if (count >= divisor) begin
         count <= 16'h0000;
         sclk  <= ~sclk;
      end else begin
         count <= count + 16'h0001;
      end
   end
   assign fall = run & sclk & (count >= divisor);
endmodule // ssr_clkgen

// File: dv/ssr_receiver_checker.sv
// Assertions on the receiver bus, serial clock and interrupt pins
`timescale 1ns/1ns
module ssr_receiver_checker (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o,
   input  wire logic        sclk_out,
   input  wire logic        sclk_oe,
   input  wire logic        low_power,
   input  wire logic        irq,
   input  wire logic        wake
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   property p_ack_resp;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   property p_ack_cause;
      wb_ack_o |-> wb_cyc_i && wb_stb_i;
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_dat_hi;
      wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
   endproperty
   a_dat_hi: assert property (p_dat_hi) else $error("upper bits set");
   property p_unmapped;
      wb_ack_o && !wb_we_i && wb_adr_i[5:2] > 4'h6 |-> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("hole read");
   property p_wake;
      wake == (irq && low_power);
   endproperty
   a_wake: assert property (p_wake) else $error("wake wrong");
   property p_irq_fall;
      $fell(irq) |-> wb_ack_o || $past(wb_ack_o);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
   property p_idle_clk;
      !sclk_oe && !$past(sclk_oe) |-> sclk_out;
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("clock idle");
   property p_oe_toggle;
      $changed(sclk_out) |-> sclk_oe || $past(sclk_oe);
   endproperty
   a_oe_toggle: assert property (p_oe_toggle) else $error("slave clk");
endmodule // ssr_receiver_checker

bind ssr_receiver ssr_receiver_checker chk_i (.clk(clk), .nrst(nrst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .sclk_out(sclk_out), .sclk_oe(sclk_oe), .low_power(low_power),
   .irq(irq), .wake(wake));

// File: dv/ssr_tx_model.sv
// External synchronous transmitter sharing clock and data lines
`timescale 1ns/1ns
module ssr_tx_model (
   input  wire logic clk,
   input  wire logic sclk_out,
   output logic      sclk_in,
   output logic      dout
);
   initial begin
      sclk_in = 1'b1;
      dout = 1'b0;
   end
   // Slave frame: clock made here, data set while high
   task automatic send_s(input logic [8:0] w, input int n);
      #13;
      for (int i = 0; i < n; i++) begin
         dout = w[i];
         #200 sclk_in = 1'b0;
         #200 sclk_in = 1'b1;
      end
      dout = ~w[n-1];
   endtask
   // Master frame: next bit a few cycles after each fall
   task automatic send_m(input logic [8:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         dout = w[i];
         @(negedge sclk_out);
         repeat (4) @(posedge clk);
         #3;
      end
      dout = ~w[n-1];
   endtask
endmodule // ssr_tx_model

// File: dv/testbench.sv
// Self-checking bench for the synchronous serial receiver
`timescale 1ns/1ns
module testbench;
   import ssr_pkg::*;
   logic        clk, nrst, cyc, stb, we, low_power;
   logic [5:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, rd, seed;
   logic        ack, sclk_out, sclk_oe, irq, wake, sclk_in, sdata;
   logic [8:0]  w [4];
   int          error_cnt, checked;

   ssr_receiver uut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .rx_data_pin(sdata),
      .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
      .low_power(low_power), .irq(irq), .wake(wake));
   ssr_tx_model model_i (.clk(clk), .sclk_out(sclk_out),
      .sclk_in(sclk_in), .dout(sdata));

   initial clk = 1'b0;
   always #25 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (error_cnt == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] stat(input logic [7:0] c, input logic n9);
      return {24'h0, c[7:1], n9};
   endfunction
   // One classic Wishbone cycle; read data lands in rd
   task automatic bus(input logic [3:0] idx, input logic w_en,
                      input logic [7:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w_en;
      adr <= {idx, 2'b00};
      sel <= 4'hF;
      wdat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         error_cnt++;
         test_done();
      end
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wait_flag;
      int n;
      n = 0;
      do begin
         bus(ADDR_IRQ, 1'b0, 8'h00);
         n++;
      end while (rd[BIT_IRQ_FLAG] !== 1'b1 && n < 400);
      if (rd[BIT_IRQ_FLAG] !== 1'b1) begin
         error_cnt++;
         test_done();
      end
   endtask

   initial begin
      repeat (50000) @(posedge clk);
      error_cnt++;
      test_done();
   end

   initial begin
      seed = 32'hFB9A;
      error_cnt = 0;
      checked = 0;
      nrst = 1'b0;
      {cyc, stb, we, low_power, adr, sel, wdat} = '0;
      for (int i = 0; i < 4; i++)
         w[i] = 9'(xs());
      w[0][8] = 1'b1;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      // Reset values, and a hole that ignores writes
      for (int i = 0; i < 10; i++) begin
         if (i == 9)
            bus(4'h9, 1'b1, 8'hFF);
         bus(4'(i), 1'b0, 8'h00);
         chk(rd, 32'h0);
      end
      // Slave, nine bits, continuous, asleep with irq on
      bus(ADDR_TX_CTRL, 1'b1, 8'h10);
      bus(ADDR_IRQ, 1'b1, 8'h01);
      bus(ADDR_RX_CTRL, 1'b1, 8'hD0);
      chk({31'h0, sclk_oe}, 32'h0);
      low_power <= 1'b1;
      model_i.send_s(w[0], 9);
      wait_flag();
      chk({31'h0, wake}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      low_power <= 1'b0;
      bus(ADDR_RX_CTRL, 1'b0, 8'h00);
      chk(rd, stat(8'hD0, w[0][8]));
      bus(ADDR_RX_BUF, 1'b0, 8'h00);
      chk(rd, {24'h0, w[0][7:0]});
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      // Slave, eight bits, irq masked, three words overrun
      bus(ADDR_IRQ, 1'b1, 8'h00);
      bus(ADDR_RX_CTRL, 1'b1, 8'h90);
      for (int i = 1; i < 4; i++)
         model_i.send_s(w[i], 8);
      chk({31'h0, irq}, 32'h0);
      bus(ADDR_RX_CTRL, 1'b0, 8'h00);
      chk(rd & 32'hFE, 32'h92);
      for (int i = 1; i < 3; i++) begin
         bus(ADDR_RX_BUF, 1'b0, 8'h00);
         chk(rd, {24'h0, w[i][7:0]});
      end
      bus(ADDR_IRQ, 1'b0, 8'h00);
      chk(rd, 32'h0);
      bus(ADDR_RX_CTRL, 1'b1, 8'h80);
      bus(ADDR_RX_CTRL, 1'b0, 8'h00);
      chk(rd & 32'hFE, 32'h80);
      // Slave ignores the single enable
      bus(ADDR_RX_CTRL, 1'b1, 8'hA0);
      model_i.send_s(w[3], 8);
      bus(ADDR_IRQ, 1'b0, 8'h00);
      chk(rd, 32'h0);
      bus(ADDR_RX_CTRL, 1'b1, 8'h80);
      // Master, single word
      bus(ADDR_DIV_LOW, 1'b1, 8'h07);
      bus(ADDR_DIV_HIGH, 1'b1, 8'h00);
      bus(ADDR_TX_CTRL, 1'b1, 8'h90);
      chk({31'h0, sclk_oe}, 32'h1);
      fork
         model_i.send_m(w[0], 8);
      join_none
      bus(ADDR_RX_CTRL, 1'b1, 8'hA0);
      wait_flag();
      bus(ADDR_RX_BUF, 1'b0, 8'h00);
      chk(rd, {24'h0, w[0][7:0]});
      repeat (40) @(posedge clk);
      chk({31'h0, sclk_out}, 32'h1);
      bus(ADDR_RX_CTRL, 1'b0, 8'h00);
      chk(rd & 32'hFE, 32'h80);
      // Master, both enables: continuous wins
      fork
         bus(ADDR_RX_CTRL, 1'b1, 8'hB0);
      join_none
      model_i.send_m(w[1], 8);
      @(posedge clk);
      model_i.send_m(w[2], 8);
      for (int i = 1; i < 3; i++) begin
         bus(ADDR_RX_BUF, 1'b0, 8'h00);
         chk(rd, {24'h0, w[i][7:0]});
      end
      bus(ADDR_RX_CTRL, 1'b0, 8'h00);
      chk(rd & 32'hFE, 32'hB0);
      bus(ADDR_RX_CTRL, 1'b1, 8'h80);
      test_done();
   end
endmodule // testbench
